/* hdl/ccp_pkg.sv */
// Constants, field positions and types for the channel mode control block.
// Assumes a single 50 MHz system clock and a 32-bit AXI4-Lite register bus.
// Summary of operation
// - DS3/STS-1 PRBS generator runs 2^15-1 sequence.
// - E3 PRBS generator runs 2^23-1 sequence.
// - Enabled checker hunts sequence of current rate.
// - Bit 5 enables generator and checker together.
// - PRBS forces single-rail operation throughout test.
// - Negative/violation output flags every PRBS error once the checker is locked.
// - Each PRBS error after lock counts in 16-bit counter until it saturates.
// - PRBS replaces both system transmit data inputs.
// - Bits 3 and 4 select loop-back mode.
// - Bit 2 selects E3 or DS3/STS-1 family.
// - Bit 1 picks DS3/STS-1, ignored under E3.
// - Single rail: encoder on, positive rails only.
package ccp_pkg;
  localparam int ADDR_W = 8;
  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [ADDR_W-1:0] CMC_IDX = 8'h06;
  localparam logic [ADDR_W-1:0] IRQ_STAT_IDX = 8'h07;
  localparam logic [ADDR_W-1:0] IRQ_MASK_IDX = 8'h08;
  localparam logic [ADDR_W-1:0] ERR_CNT_IDX = 8'h09;
  localparam logic [ADDR_W-1:0] LOCK_IDX = 8'h0A;
  localparam logic [ADDR_W-1:0] CMC_ADDR = ADDR_W'(CMC_IDX * 4);
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = ADDR_W'(IRQ_STAT_IDX * 4);
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = ADDR_W'(IRQ_MASK_IDX * 4);
  localparam logic [ADDR_W-1:0] ERR_CNT_ADDR = ADDR_W'(ERR_CNT_IDX * 4);
  localparam logic [ADDR_W-1:0] LOCK_ADDR = ADDR_W'(LOCK_IDX * 4);
  // Control register fields.
  localparam int CMC_W = 6;
  localparam logic [CMC_W-1:0] CMC_RESET = 6'h00;
  localparam int BIT_PRBS = 5;
  localparam int BIT_REMOTE = 4;
  localparam int BIT_LOCAL = 3;
  localparam int BIT_E3 = 2;
  localparam int BIT_NA_RATE = 1;
  localparam int BIT_RAIL = 0;
  // Interrupt status and mask fields.
  localparam int IRQ_W = 2;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_LOCK = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  localparam int ERR_W = 16;
  // PRBS lengths and feedback taps (bit 0 holds the newest bit).
  localparam int LFSR_W = 23;
  localparam int SHORT_LEN = 15;
  localparam int SHORT_TAP_A = 14;
  localparam int SHORT_TAP_B = 13;
  localparam int LONG_TAP_A = 22;
  localparam int LONG_TAP_B = 17;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h7FFFFF;
  localparam int SYNC_LEN = 32;
  localparam int SYNC_W = 6;
  localparam int SYNC_STAGES = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CCP_LOOP_NONE = 2'b00,
    CCP_LOOP_REMOTE = 2'b01,
    CCP_LOOP_ANALOG = 2'b10,
    CCP_LOOP_DIGITAL = 2'b11
  } ccp_loop_t;
  typedef enum logic {
    CCP_HUNT = 1'b0,
    CCP_LOCKED = 1'b1
  } ccp_chk_t;
endpackage : ccp_pkg

/* hdl/ccp_channel_ctrl.sv */
// One line-interface channel: control register, loop-back, rate select and PRBS test.
// Line and system pins arrive asynchronously and are sampled on aclk; the bus is AXI4-Lite.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module ccp_channel_ctrl
  import ccp_pkg::*;
#(
  parameter int SYNC_MATCHES = ccp_pkg::SYNC_LEN
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ccp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ccp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_line_clock_in,
  input wire logic tx_positive_data_in,
  input wire logic tx_negative_data_in,
  input wire logic rx_line_clock_in,
  input wire logic rx_line_positive_in,
  input wire logic rx_line_negative_in,
  input wire logic rx_line_violation_in,
  output logic tx_line_positive_out,
  output logic tx_line_negative_out,
  output logic rx_positive_data_out,
  output logic rx_negative_or_violation_out,
  output logic line_codec_enable,
  output logic rate_e3,
  output logic rate_sts1,
  output ccp_pkg::ccp_loop_t loop_mode,
  output logic irq
);
  import ccp_pkg::*;

  typedef struct packed {
    logic [CMC_W-1:0] cmc;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [ERR_W-1:0] err_cnt;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [SYNC_STAGES-1:0] txc_s;
    logic [SYNC_STAGES-1:0] txp_s;
    logic [SYNC_STAGES-1:0] txn_s;
    logic [SYNC_STAGES-1:0] rxc_s;
    logic [SYNC_STAGES-1:0] rxp_s;
    logic [SYNC_STAGES-1:0] rxn_s;
    logic [SYNC_STAGES-1:0] rxv_s;
    logic txc_lvl;
    logic rxc_lvl;
    logic [LFSR_W-1:0] gen;
    logic [LFSR_W-1:0] chk;
    ccp_chk_t chk_state;
    logic [SYNC_W-1:0] match_cnt;
    logic tx_pos;
    logic tx_neg;
    logic rx_pos;
    logic rx_neg;
  } ccp_state_t;

  ccp_state_t st;
  ccp_state_t next_st;

  // Next PRBS bit for the chosen length; an all-zero window is forced out of lock-up.
  function automatic logic prbs_next(input logic [LFSR_W-1:0] s, input logic long_seq);
    logic zero;
    zero = long_seq ? (s == '0) : (s[SHORT_LEN-1:0] == '0);
    if (long_seq)
      prbs_next = s[LONG_TAP_A] ^ s[LONG_TAP_B] ^ zero;
    else
      prbs_next = s[SHORT_TAP_A] ^ s[SHORT_TAP_B] ^ zero;
  endfunction : prbs_next

  // Shifts a pin into a three-stage synchroniser; stage 0 is read only by stage 1.
  function automatic logic [SYNC_STAGES-1:0] sync_in(input logic [SYNC_STAGES-1:0] s,
                                                     input logic pin);
    sync_in = {s[SYNC_STAGES-2:0], pin};
  endfunction : sync_in

  // A clock edge counts once stages two and three agree on a new high level.
  function automatic logic rise_seen(input logic [SYNC_STAGES-1:0] s, input logic lvl);
    rise_seen = (s[1] == s[2]) && s[2] && !lvl;
  endfunction : rise_seen

  function automatic logic settled(input logic [SYNC_STAGES-1:0] s, input logic lvl);
    settled = (s[1] == s[2]) ? s[2] : lvl;
  endfunction : settled

  logic prbs_on;
  logic e3_mode;
  logic single_rail;
  logic tx_edge;
  logic rx_edge;
  logic gen_bit;
  logic tx_pos_src;
  logic tx_neg_src;
  logic chk_in;
  logic chk_err;
  logic err_pulse;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [31:0] read_word;
  logic [1:0] read_resp;

  // Mode decode from the control register.
  assign prbs_on = st.cmc[BIT_PRBS];
  assign e3_mode = st.cmc[BIT_E3];
  assign single_rail = st.cmc[BIT_RAIL] | prbs_on;
  assign tx_edge = rise_seen(st.txc_s, st.txc_lvl);
  assign rx_edge = rise_seen(st.rxc_s, st.rxc_lvl);
  assign gen_bit = prbs_next(st.gen, e3_mode);

  // Transmit source: the generator overrides both system inputs during a test.
  always_comb
  begin
    if (prbs_on)
    begin
      tx_pos_src = gen_bit;
      tx_neg_src = 1'b0;
    end
    else
    begin
      tx_pos_src = st.txp_s[2];
      tx_neg_src = single_rail ? 1'b0 : st.txn_s[2];
    end
  end

  // Local loop feeds the checker and positive receive output from the transmit path; the negative output only in dual rail.
  // Analog and digital local loops look alike here; the analog path is outside.
  assign chk_in = st.cmc[BIT_LOCAL] ? tx_pos_src : st.rxp_s[2];
  assign chk_err = (chk_in != prbs_next(st.chk, e3_mode));
  assign err_pulse = prbs_on && rx_edge && (st.chk_state == CCP_LOCKED) && chk_err;

  // Bus handshakes: one write and one read slot, each answered before the next is taken.
  assign s_axi_awready = !st.aw_full && !st.bvalid;
  assign s_axi_wready = !st.w_full && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // Read decode; unmapped addresses answer with a slave error and zero data.
  always_comb
  begin
    read_word = 32'h0000_0000;
    read_resp = RESP_OKAY;
    unique case (s_axi_araddr)
      CMC_ADDR: read_word[CMC_W-1:0] = st.cmc;
      IRQ_STAT_ADDR: read_word[IRQ_W-1:0] = st.irq_stat;
      IRQ_MASK_ADDR: read_word[IRQ_W-1:0] = st.irq_mask;
      ERR_CNT_ADDR: read_word[ERR_W-1:0] = st.err_cnt;
      LOCK_ADDR: read_word[0] = (st.chk_state == CCP_LOCKED);
      default: read_resp = RESP_SLVERR;
    endcase
  end

  // Whole next state of the block.
  always_comb
  begin
    next_st = st;
    next_st.txc_s = sync_in(st.txc_s, tx_line_clock_in);
    next_st.txp_s = sync_in(st.txp_s, tx_positive_data_in);
    next_st.txn_s = sync_in(st.txn_s, tx_negative_data_in);
    next_st.rxc_s = sync_in(st.rxc_s, rx_line_clock_in);
    next_st.rxp_s = sync_in(st.rxp_s, rx_line_positive_in);
    next_st.rxn_s = sync_in(st.rxn_s, rx_line_negative_in);
    next_st.rxv_s = sync_in(st.rxv_s, rx_line_violation_in);
    next_st.txc_lvl = settled(st.txc_s, st.txc_lvl);
    next_st.rxc_lvl = settled(st.rxc_s, st.rxc_lvl);
    // Write channel: address and data may arrive in either order.
    if (aw_take)
    begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (st.aw_full && st.w_full)
    begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case (st.aw_addr)
        CMC_ADDR:
        begin
          if (st.w_lane0)
            next_st.cmc = st.w_data[CMC_W-1:0];
        end
        IRQ_MASK_ADDR:
        begin
          if (st.w_lane0)
            next_st.irq_mask = st.w_data[IRQ_W-1:0];
        end
        IRQ_STAT_ADDR, ERR_CNT_ADDR, LOCK_ADDR: next_st.bresp = RESP_OKAY;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // Read channel; reading status or counter clears it before new events land.
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (ar_take)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = read_word;
      next_st.rresp = read_resp;
      if (s_axi_araddr == IRQ_STAT_ADDR)
        next_st.irq_stat = IRQ_RESET;
      if (s_axi_araddr == ERR_CNT_ADDR)
        next_st.err_cnt = '0;
    end
    // Transmit side, advanced on each recovered edge of the transmit clock.
    if (tx_edge)
    begin
      if (prbs_on)
        next_st.gen = {st.gen[LFSR_W-2:0], gen_bit};
      if (st.cmc[BIT_REMOTE] && !st.cmc[BIT_LOCAL])
      begin
        next_st.tx_pos = st.rxp_s[2];
        next_st.tx_neg = single_rail ? 1'b0 : st.rxn_s[2];
      end
      else
      begin
        next_st.tx_pos = tx_pos_src;
        next_st.tx_neg = tx_neg_src;
      end
    end
    // Receive side and checker, advanced on each rising edge of the receive clock.
    if (rx_edge)
    begin
      next_st.rx_pos = chk_in;
      if (prbs_on)
        next_st.rx_neg = err_pulse;
      else if (single_rail)
        next_st.rx_neg = st.rxv_s[2];
      else
        next_st.rx_neg = st.cmc[BIT_LOCAL] ? tx_neg_src : st.rxn_s[2];
      if (prbs_on)
      begin
        next_st.chk = {st.chk[LFSR_W-2:0], chk_in};
        if (st.chk_state == CCP_HUNT)
        begin
          if (chk_err)
            next_st.match_cnt = '0;
          else if (st.match_cnt == SYNC_W'(SYNC_MATCHES - 1))
          begin
            next_st.chk_state = CCP_LOCKED;
            next_st.irq_stat[IRQ_LOCK] = 1'b1;
          end
          else
            next_st.match_cnt = st.match_cnt + 1'b1;
        end
      end
    end
    // Errors saturate the counter; a set beats a same-cycle read clear.
    if (err_pulse)
    begin
      next_st.irq_stat[IRQ_ERR] = 1'b1;
      if (st.err_cnt != '1)
        next_st.err_cnt = next_st.err_cnt + 1'b1;
    end
    // Disabling the test drops lock so the next run hunts afresh.
    if (!prbs_on)
    begin
      next_st.chk_state = CCP_HUNT;
      next_st.match_cnt = '0;
    end
  end

  // Single register stage for all state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.cmc <= CMC_RESET;
      st.gen <= LFSR_SEED;
      st.chk <= LFSR_SEED;
      st.chk_state <= CCP_HUNT;
    end
    else
      st <= next_st;
  end

  // Outputs straight from flip-flops, except the mode decodes and interrupt.
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign tx_line_positive_out = st.tx_pos;
  assign tx_line_negative_out = st.tx_neg;
  assign rx_positive_data_out = st.rx_pos;
  assign rx_negative_or_violation_out = st.rx_neg;
  assign line_codec_enable = single_rail;
  assign rate_e3 = e3_mode;
  assign rate_sts1 = !e3_mode && st.cmc[BIT_NA_RATE];
  assign loop_mode = ccp_loop_t'({st.cmc[BIT_LOCAL], st.cmc[BIT_REMOTE]});
  assign irq = |(st.irq_stat & st.irq_mask);

  sequence s_err_seen;
    err_pulse ##1 1'b1;
  endsequence

  a_prbs_gates_gen: assert property (@(posedge aclk) disable iff (!aresetn)
    (!prbs_on && tx_edge) |=> $stable(st.gen))
    else $error("Generator advanced while the test was off.");
  a_sts_ignored_e3: assert property (@(posedge aclk) disable iff (!aresetn)
    e3_mode |-> !rate_sts1)
    else $error("North American rate shown under E3.");
  a_err_flag_out: assert property (@(posedge aclk) disable iff (!aresetn)
    s_err_seen |-> rx_negative_or_violation_out)
    else $error("Checker error not flagged on the negative output.");
  a_err_counted: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_pulse && !ar_take && st.err_cnt != '1) |=> st.err_cnt == $past(st.err_cnt) + 1'b1)
    else $error("Checker error not counted.");
  a_hunt_no_err: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.chk_state == CCP_HUNT) |-> !err_pulse)
    else $error("Error flagged before lock.");
  a_tx_override: assert property (@(posedge aclk) disable iff (!aresetn)
    (prbs_on && tx_edge && loop_mode == CCP_LOOP_NONE) |=> !tx_line_negative_out
      && tx_line_positive_out == $past(gen_bit))
    else $error("System data reached the line during the test.");
  a_single_rail: assert property (@(posedge aclk) disable iff (!aresetn)
    prbs_on |-> line_codec_enable)
    else $error("Dual rail kept during the test.");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && $past(ar_take) && $past(s_axi_araddr) == CMC_ADDR)
      |-> s_axi_rdata[31:CMC_W] == '0)
    else $error("Reserved control bits read nonzero.");
  a_loop_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_edge && loop_mode == CCP_LOOP_REMOTE)
      |=> tx_line_positive_out == $past(st.rxp_s[2]))
    else $error("Remote loop did not return received data.");
  a_local_loop: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_edge && st.cmc[BIT_LOCAL]) |=> rx_positive_data_out == $past(tx_pos_src))
    else $error("Local loop did not return transmit data.");
  a_lock_after_run: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st.chk_state == CCP_LOCKED) |-> $past(prbs_on) && $past(st.match_cnt) ==
      SYNC_W'(SYNC_MATCHES - 1))
    else $error("Lock declared without a full matching run.");
endmodule : ccp_channel_ctrl
`default_nettype wire

/* testbench/ccp_far_model.sv */
// Far-side model: system framer making the transmit clock and data, plus a line loop
// that returns the transmitted positive rail as recovered receive data and clock.
// Assumes the device under test drives line_pos from its transmit positive output.
`timescale 1ns/10ps
`default_nettype none
module ccp_far_model (
  input wire logic run,
  input wire logic inject,
  input wire logic line_pos,
  output logic tx_clk,
  output logic tx_pos,
  output logic tx_neg,
  output logic rx_clk,
  output logic rx_pos
);
  // The line clock stands still while run is low; otherwise it is steady at 160 ns.
  initial
  begin
    tx_clk = 1'b0;
    forever
    begin
      #80;
      tx_clk = run ? ~tx_clk : 1'b0;
    end
  end

  // System data toggles every bit on complementary rails, so any leak onto the line shows.
  // The same process keeps one bit of line delay, corrupted on demand.
  initial
  begin
    tx_pos = 1'b0;
    tx_neg = 1'b1;
    rx_pos = 1'b0;
    forever
    begin
      @(posedge tx_clk);
      tx_pos <= ~tx_pos;
      tx_neg <= tx_pos;
      rx_pos <= line_pos ^ inject;
    end
  end

  // The receive clock lags half a bit so the returned bit is steady around its rising edge.
  initial
  begin
    rx_clk = 1'b0;
    forever
    begin
      @(tx_clk);
      rx_clk <= #80 tx_clk;
    end
  end
endmodule : ccp_far_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the channel control block: register table rows, then PRBS cases.
// Assumes the far-side model loops the transmit positive rail back to the receive side.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ccp_pkg::*;
  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] rd;
    logic e3;
    logic sts1;
    logic [1:0] loop;
    logic codec;
  } ccp_row_t;
  localparam ccp_row_t ROWS [9] = '{
    '{8'h00, 8'h00, 1'b0, 1'b0, 2'h0, 1'b0}, '{8'h02, 8'h02, 1'b0, 1'b1, 2'h0, 1'b0},
    '{8'h04, 8'h04, 1'b1, 1'b0, 2'h0, 1'b0}, '{8'h06, 8'h06, 1'b1, 1'b0, 2'h0, 1'b0},
    '{8'h10, 8'h10, 1'b0, 1'b0, 2'h1, 1'b0}, '{8'h08, 8'h08, 1'b0, 1'b0, 2'h2, 1'b0},
    '{8'h18, 8'h18, 1'b0, 1'b0, 2'h3, 1'b0}, '{8'hC1, 8'h01, 1'b0, 1'b0, 2'h0, 1'b1},
    '{8'h20, 8'h20, 1'b0, 1'b0, 2'h0, 1'b1}};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic tx_clk, tx_pos, tx_neg, rx_clk, rx_pos, run, inject, seen;
  logic tx_line_positive_out, tx_line_negative_out, rx_positive_data_out;
  logic rx_negative_or_violation_out, line_codec_enable, rate_e3, rate_sts1, irq;
  ccp_loop_t loop_mode;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;

  ccp_channel_ctrl #(.SYNC_MATCHES(16)) ccp_channel_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_line_clock_in(tx_clk), .tx_positive_data_in(tx_pos),
    .tx_negative_data_in(tx_neg), .rx_line_clock_in(rx_clk), .rx_line_positive_in(rx_pos),
    .rx_line_negative_in(1'b0), .rx_line_violation_in(1'b0), .tx_line_positive_out,
    .tx_line_negative_out, .rx_positive_data_out, .rx_negative_or_violation_out,
    .line_codec_enable, .rate_e3, .rate_sts1, .loop_mode, .irq);

  ccp_far_model ccp_far_model_inst (.run(run), .inject(inject), .line_pos(tx_line_positive_out),
    .tx_clk(tx_clk), .tx_pos(tx_pos), .tx_neg(tx_neg), .rx_clk(rx_clk), .rx_pos(rx_pos));

  // 50 MHz system clock.
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // A hung handshake or lost link ends the run here rather than stalling forever.
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : check

  // Write: address and data offered together, each released when taken, then the response.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Line bits sampled at each transmit clock rise must obey the feedback recurrence.
  task automatic prbs_chk(input int n, input int ta, input int tb);
    logic [63:0] s;
    logic [63:0] q;
    s = '0;
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge tx_clk);
      s = {s[62:0], tx_line_positive_out};
      q = {q[62:0], rx_positive_data_out};
      check(32'(tx_line_negative_out), 32'h0);
      if (i >= ta) check(32'(s[0]), 32'(s[ta] ^ s[tb]));
      if (i >= ta) check(32'(q[0]), 32'(q[ta] ^ q[tb]));
    end
    check(32'((s[39:0] != '0) && (s[39:0] != '1)), 32'h1);
  endtask : prbs_chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    run = 1'b1;
    inject = 1'b0;
    seen = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(irq), 32'h0);
    rd(CMC_ADDR, d, r);
    check(d, 32'h0);
    rd(IRQ_STAT_ADDR, d, r);
    check(d, 32'h0);
    rd(8'h3C, d, r);
    check({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(8'h3C, 32'hFF, r);
    check(32'(r), 32'(RESP_SLVERR));
    // A write whose low byte lane is off must leave the register alone.
    s_axi_wstrb <= 4'hE;
    wr(CMC_ADDR, 32'h3F, r);
    s_axi_wstrb <= 4'hF;
    rd(CMC_ADDR, d, r);
    check(d, 32'h0);
    $display("reset and decode test done");
    // Control register rows: decoded mode pins and read-back.
    foreach (ROWS[i])
    begin
      wr(CMC_ADDR, 32'(ROWS[i].wr), r);
      rd(CMC_ADDR, d, r);
      check(d, 32'(ROWS[i].rd));
      check(32'({rate_e3, rate_sts1}), 32'({ROWS[i].e3, ROWS[i].sts1}));
      check(32'(loop_mode), 32'(ROWS[i].loop));
      check(32'(line_codec_enable), 32'(ROWS[i].codec));
    end
    $display("register rows test done");
    // Short sequence, masked interrupt, lock and then a single injected line error.
    wr(IRQ_MASK_ADDR, 32'h0, r);
    wr(CMC_ADDR, 32'h21, r);
    repeat (40) @(posedge tx_clk);
    prbs_chk(40, 15, 14);
    rd(LOCK_ADDR, d, r);
    check(d, 32'h1);
    check(32'(irq), 32'h0);
    wr(IRQ_MASK_ADDR, 32'h3, r);
    check(32'(irq), 32'h1);
    rd(IRQ_STAT_ADDR, d, r);
    check(d, 32'h2);
    check(32'(irq), 32'h0);
    rd(ERR_CNT_ADDR, d, r);
    check(d, 32'h0);
    @(posedge tx_clk);
    inject <= 1'b1;
    @(posedge tx_clk);
    inject <= 1'b0;
    repeat (320)
    begin
      @(posedge aclk);
      if (rx_negative_or_violation_out === 1'b1) seen = 1'b1;
    end
    check(32'(seen), 32'h1);
    // A self-synchronising checker sees the bad bit itself and again at both taps.
    rd(ERR_CNT_ADDR, d, r);
    check(d, 32'h3);
    rd(IRQ_STAT_ADDR, d, r);
    check(d, 32'h1);
    $display("short sequence test done");
    // Long sequence, with the rate-select bit set to show it is ignored.
    wr(CMC_ADDR, 32'h27, r);
    repeat (40) @(posedge tx_clk);
    prbs_chk(60, 23, 18);
    // Clearing the enable stops the checker and returns the system rails to the line.
    wr(CMC_ADDR, 32'h00, r);
    repeat (10) @(posedge tx_clk);
    rd(LOCK_ADDR, d, r);
    check(d, 32'h0);
    repeat (4)
    begin
      @(posedge tx_clk);
      check(32'(tx_line_positive_out ^ tx_line_negative_out), 32'h1);
    end
    $display("long sequence and disable test done");
    // A reset in mid-run returns every field and the loop decode to idle.
    wr(CMC_ADDR, 32'h3F, r);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(loop_mode), 32'h0);
    check(32'(irq), 32'h0);
    rd(CMC_ADDR, d, r);
    check(d, 32'h0);
    rd(ERR_CNT_ADDR, d, r);
    check(d, 32'h0);
    $display("mid-run reset test done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
